// >>> srer_pkg.sv
// Purpose: shared constants and types for the stream read error report
// Assumes: 200 MHz clock, APB register access, 32-bit data
// Notes:   byte offsets of the register map, field positions, resets
package srer_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and time limits
    localparam int unsigned SRER_CLK_MHZ      = 200;
    localparam int unsigned SRER_COMPLETION_TIME_LIMIT_MIN_MS  = 50;
    localparam int unsigned SRER_COMPLETION_TIME_LIMIT_MIN_CYC =
        SRER_COMPLETION_TIME_LIMIT_MIN_MS * 1000 * SRER_CLK_MHZ;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] SRER_OFS_CTRL    = 8'h00;
    localparam logic [7:0] SRER_OFS_FEATURE = 8'h04;
    localparam logic [7:0] SRER_OFS_DEFCCTL = 8'h08;
    localparam logic [7:0] SRER_OFS_CMD     = 8'h0C;
    localparam logic [7:0] SRER_OFS_STATUS  = 8'h10;
    localparam logic [7:0] SRER_OFS_ERROR   = 8'h14;
    localparam logic [7:0] SRER_OFS_SECNUM  = 8'h18;
    localparam logic [7:0] SRER_OFS_CYLLO   = 8'h1C;
    localparam logic [7:0] SRER_OFS_CYLHI   = 8'h20;
    localparam logic [7:0] SRER_OFS_SECCNT  = 8'h24;
    localparam logic [7:0] SRER_OFS_ERRLOG  = 8'h28;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned SRER_CTRL_HBS_BIT = 0;
    localparam int unsigned SRER_FEAT_RC_BIT  = 6;
    localparam int unsigned SRER_ST_BSY_BIT   = 7;
    localparam int unsigned SRER_ST_RDY_BIT   = 6;
    localparam int unsigned SRER_ST_SE_BIT    = 5;
    localparam int unsigned SRER_ST_ERR_BIT   = 0;
    localparam int unsigned SRER_ER_CRC_BIT   = 7;
    localparam int unsigned SRER_ER_UNC_BIT   = 6;
    localparam int unsigned SRER_ER_ADDRESS_NOT_FOUND_ERROR_BIT  = 4;
    localparam int unsigned SRER_ER_ABORTED_COMMAND_ERROR_BIT  = 2;
    localparam int unsigned SRER_ER_TIME_LIMIT_EXPIRED_FLAG_BIT  = 0;

    ////////////////////////////////////////////////////////////////////////
    // reset values, busy status and count ceiling
    localparam logic [7:0]  SRER_STATUS_RST  = 8'h40;
    localparam logic [7:0]  SRER_STATUS_BUSY = 8'h80;
    localparam logic [15:0] SRER_FEATURE_RST = 16'h0000;
    localparam logic [7:0]  SRER_BYTE_RST    = 8'h00;
    localparam logic [15:0] SRER_CNT_MAX     = 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_END  = 3'b100
    } srer_state_type;

    typedef struct packed {
        logic crc;
        logic uncorrectable_error;
        logic address_not_found_error;
        logic aborted_command_error;
    } srer_err_type;

    typedef struct packed {
        logic         valid;
        logic [47:0]  lba;
        srer_err_type err;
    } srer_media_type;

    function automatic logic [7:0] srer_err_byte(input srer_err_type e,
                                                 input logic time_limit_expired_flag);
        logic [7:0] b;
        b = 8'h00;
        b[SRER_ER_CRC_BIT]  = e.crc;
        b[SRER_ER_UNC_BIT]  = e.uncorrectable_error;
        b[SRER_ER_ADDRESS_NOT_FOUND_ERROR_BIT] = e.address_not_found_error;
        b[SRER_ER_ABORTED_COMMAND_ERROR_BIT] = e.aborted_command_error;
        b[SRER_ER_TIME_LIMIT_EXPIRED_FLAG_BIT] = time_limit_expired_flag;
        return b;
    endfunction : srer_err_byte

endpackage : srer_pkg

// >>> srer_limit_timer.sv
// Purpose: command completion time limit counter
// Assumes: arm_i is a one-cycle pulse at command start
// Notes:   a requested limit below the floor is raised to the floor
`timescale 1ns/1ps
`default_nettype none
module srer_limit_timer
#(
    parameter int unsigned MIN_CYC = 10000000
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        arm_i,
    input  wire logic        en_i,
    input  wire logic        stop_i,
    input  wire logic [31:0] req_cyc_i,
    output logic             expired_o
);

    localparam logic [31:0] MIN_L = 32'(MIN_CYC);

    logic [31:0] lim_q;
    logic [31:0] cnt_q;
    logic        run_q;
    logic        exp_q;
    logic [31:0] lim_w;
    logic        hit_w;

    assign lim_w     = (req_cyc_i < MIN_L) ? MIN_L : req_cyc_i;
    assign hit_w     = run_q && ((cnt_q + 32'h00000001) >= lim_q);
    assign expired_o = exp_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lim_q <= 32'h00000000;
            cnt_q <= 32'h00000000;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end
        else if (ce_i)
        begin
            exp_q <= hit_w && !stop_i;
            if (arm_i)
            begin
                lim_q <= lim_w;
                cnt_q <= 32'h00000000;
                run_q <= en_i;
            end
            else if (stop_i || hit_w)
                run_q <= 1'b0;
            if (run_q && !arm_i)
                cnt_q <= cnt_q + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    limit_floor_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        expired_o |-> (cnt_q >= MIN_L)
    ) else $error("time limit expired before the minimum");

endmodule : srer_limit_timer
`default_nettype wire

// >>> srer_top.sv
// Purpose: result and error reporting for a streaming sector read
// Assumes: media side reports errors and transfer end as pulses
// Notes:   registers over APB, zero wait states when ce_i is high
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module srer_top
    import srer_pkg::*;
#(
    parameter int unsigned COMPLETION_TIME_LIMIT_MIN_CYC = SRER_COMPLETION_TIME_LIMIT_MIN_CYC,
    parameter int unsigned COMPLETION_TIME_LIMIT_UNIT_US = 1000
)(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           ce_i,
    input  wire logic           psel_i,
    input  wire logic           penable_i,
    input  wire logic           pwrite_i,
    input  wire logic [31:0]    paddr_i,
    input  wire logic [31:0]    pwdata_i,
    output logic      [31:0]    prdata_o,
    output logic                pready_o,
    output logic                pslverr_o,
    input  wire srer_media_type media_i,
    input  wire logic           xfer_done_i,
    output logic                busy_o,
    output logic                cont_read_o,
    output logic                stop_xfer_o,
    output logic                cmd_end_o
);

    localparam logic [31:0] UNIT_CYC = 32'(COMPLETION_TIME_LIMIT_UNIT_US * SRER_CLK_MHZ);

    ////////////////////////////////////////////////////////////////////////
    // state
    srer_state_type state_q;
    logic           hbs_q;
    logic [15:0]    feature_q;
    logic [7:0]     defcctl_q;
    logic [7:0]     cmd_q;
    logic           rc_q;
    logic [47:0]    first_lba_q;
    logic [47:0]    last_lba_q;
    logic [15:0]    cnt_q;
    logic           have_err_q;
    logic           chain_q;
    srer_err_type   err_acc_q;
    logic           timeout_q;
    logic [7:0]     status_q;
    logic [7:0]     error_q;
    logic [7:0]     log_q;
    logic [47:0]    res_lba_q;
    logic [15:0]    res_cnt_q;
    logic [31:0]    prdata_q;
    logic           loaded_q;
    logic           end_q;
    logic           stop_q;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic        hit_hi_w;
    logic [7:0]  ofs_w;
    logic        sel_ctrl_w;
    logic        sel_feat_w;
    logic        sel_defc_w;
    logic        sel_cmd_w;
    logic        sel_ro_w;
    logic        mapped_w;
    logic        wr_en_w;
    logic        bad_w;
    logic [31:0] rd_mux_w;
    logic [7:0]  secnum_w;
    logic [7:0]  cyllo_w;
    logic [7:0]  cylhi_w;
    logic [7:0]  seccnt_w;

    assign hit_hi_w   = (paddr_i[31:8] == 24'h000000);
    assign ofs_w      = paddr_i[7:0];
    assign sel_ctrl_w = hit_hi_w && (ofs_w == SRER_OFS_CTRL);
    assign sel_feat_w = hit_hi_w && (ofs_w == SRER_OFS_FEATURE);
    assign sel_defc_w = hit_hi_w && (ofs_w == SRER_OFS_DEFCCTL);
    assign sel_cmd_w  = hit_hi_w && (ofs_w == SRER_OFS_CMD);
    assign sel_ro_w   = hit_hi_w && ((ofs_w == SRER_OFS_STATUS)
                      || (ofs_w == SRER_OFS_ERROR)
                      || (ofs_w == SRER_OFS_SECNUM)
                      || (ofs_w == SRER_OFS_CYLLO)
                      || (ofs_w == SRER_OFS_CYLHI)
                      || (ofs_w == SRER_OFS_SECCNT)
                      || (ofs_w == SRER_OFS_ERRLOG));
    assign mapped_w   = sel_ctrl_w || sel_feat_w || sel_defc_w
                      || sel_cmd_w || sel_ro_w;
    assign bad_w      = !mapped_w || (pwrite_i && sel_ro_w);
    assign pready_o   = psel_i && penable_i && loaded_q && ce_i;
    assign pslverr_o  = pready_o && bad_w;
    assign wr_en_w    = pready_o && pwrite_i && !bad_w;
    assign prdata_o   = prdata_q;

    // high byte select picks the upper half of each address field
    assign secnum_w = hbs_q ? res_lba_q[31:24] : res_lba_q[7:0];
    assign cyllo_w  = hbs_q ? res_lba_q[39:32] : res_lba_q[15:8];
    assign cylhi_w  = hbs_q ? res_lba_q[47:40] : res_lba_q[23:16];
    assign seccnt_w = hbs_q ? res_cnt_q[15:8]  : res_cnt_q[7:0];

    assign rd_mux_w =
        sel_ctrl_w ? {31'h00000000, hbs_q} :
        sel_feat_w ? {16'h0000, feature_q} :
        sel_defc_w ? {24'h000000, defcctl_q} :
        sel_cmd_w  ? {24'h000000, cmd_q} :
        !hit_hi_w  ? 32'h00000000 :
        (ofs_w == SRER_OFS_STATUS) ? {24'h000000, status_q} :
        (ofs_w == SRER_OFS_ERROR)  ? {24'h000000, error_q} :
        (ofs_w == SRER_OFS_SECNUM) ? {24'h000000, secnum_w} :
        (ofs_w == SRER_OFS_CYLLO)  ? {24'h000000, cyllo_w} :
        (ofs_w == SRER_OFS_CYLHI)  ? {24'h000000, cylhi_w} :
        (ofs_w == SRER_OFS_SECCNT) ? {24'h000000, seccnt_w} :
        (ofs_w == SRER_OFS_ERRLOG) ? {24'h000000, log_q} :
        32'h00000000;

    // read data captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prdata_q <= 32'h00000000;
            loaded_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (psel_i && !loaded_q)
            begin
                prdata_q <= rd_mux_w;
                loaded_q <= 1'b1;
            end
            else if (pready_o)
                loaded_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hbs_q     <= 1'b0;
            feature_q <= SRER_FEATURE_RST;
            defcctl_q <= SRER_BYTE_RST;
        end
        else if (ce_i && wr_en_w)
        begin
            if (sel_ctrl_w)
                hbs_q <= pwdata_i[SRER_CTRL_HBS_BIT];
            if (sel_feat_w)
                feature_q <= pwdata_i[15:0];
            if (sel_defc_w)
                defcctl_q <= pwdata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencing
    logic         start_w;
    logic         any_err_w;
    logic         chained_w;
    logic         expired_w;
    logic         fail_w;
    logic [7:0]   completion_time_limit_w;
    logic [31:0]  req_cyc_w;
    logic [7:0]   ebyte_w;

    assign start_w   = wr_en_w && sel_cmd_w && (state_q == ST_IDLE);
    assign any_err_w = media_i.valid && (|media_i.err);
    assign chained_w = chain_q && (media_i.lba == last_lba_q + 48'h1);
    // previous feature byte wins; zero falls back to the stored default
    assign completion_time_limit_w    = (feature_q[15:8] != 8'h00) ? feature_q[15:8]
                                                  : defcctl_q;
    assign req_cyc_w = {24'h000000, completion_time_limit_w} * UNIT_CYC;
    assign fail_w    = have_err_q || timeout_q;
    assign ebyte_w   = srer_err_byte(err_acc_q, timeout_q);
    assign busy_o      = (state_q != ST_IDLE);
    assign cont_read_o = rc_q;
    assign stop_xfer_o = stop_q;
    assign cmd_end_o   = end_q;

    srer_limit_timer #(
        .MIN_CYC   (COMPLETION_TIME_LIMIT_MIN_CYC)
    ) u_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .arm_i     (start_w),
        .en_i      (completion_time_limit_w != 8'h00),
        .stop_i    (state_q == ST_END),
        .req_cyc_i (req_cyc_w),
        .expired_o (expired_w)
    );

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q   <= ST_IDLE;
            cmd_q     <= SRER_BYTE_RST;
            rc_q      <= 1'b0;
            timeout_q <= 1'b0;
            end_q     <= 1'b0;
            stop_q    <= 1'b0;
        end
        else if (ce_i)
        begin
            end_q  <= 1'b0;
            stop_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                    if (start_w)
                    begin
                        cmd_q     <= pwdata_i[7:0];
                        rc_q      <= feature_q[SRER_FEAT_RC_BIT];
                        timeout_q <= 1'b0;
                        state_q   <= ST_RUN;
                    end
                ST_RUN:
                    if (expired_w)
                    begin
                        timeout_q <= 1'b1;
                        stop_q    <= 1'b1;
                        state_q   <= ST_END;
                    end
                    // without continuous read an error ends the command
                    else if (xfer_done_i || (any_err_w && !rc_q))
                    begin
                        stop_q  <= !xfer_done_i;
                        state_q <= ST_END;
                    end
                ST_END:
                begin
                    end_q   <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // first faulty sector and the run of consecutive faulty sectors
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            first_lba_q <= 48'h000000000000;
            last_lba_q  <= 48'h000000000000;
            cnt_q       <= 16'h0000;
            have_err_q  <= 1'b0;
            chain_q     <= 1'b0;
            err_acc_q   <= '0;
        end
        else if (ce_i)
        begin
            if (start_w)
            begin
                first_lba_q <= 48'h000000000000;
                cnt_q       <= 16'h0000;
                have_err_q  <= 1'b0;
                chain_q     <= 1'b0;
                err_acc_q   <= '0;
            end
            else if ((state_q == ST_RUN) && any_err_w)
            begin
                err_acc_q <= err_acc_q | media_i.err;
                if (!have_err_q)
                begin
                    first_lba_q <= media_i.lba;
                    last_lba_q  <= media_i.lba;
                    cnt_q       <= 16'h0001;
                    have_err_q  <= 1'b1;
                    chain_q     <= 1'b1;
                end
                else if (chained_w)
                begin
                    last_lba_q <= media_i.lba;
                    if (cnt_q != SRER_CNT_MAX)
                        cnt_q <= cnt_q + 16'h0001;
                end
                else
                    chain_q <= 1'b0;
            end
        end
    end

    // ending status; busy shows only while a command runs
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            status_q  <= SRER_STATUS_RST;
            error_q   <= SRER_BYTE_RST;
            log_q     <= SRER_BYTE_RST;
            res_lba_q <= 48'h000000000000;
            res_cnt_q <= 16'h0000;
        end
        else if (ce_i)
        begin
            if (start_w)
            begin
                status_q <= SRER_STATUS_BUSY;
                log_q    <= SRER_BYTE_RST;
            end
            else if (state_q == ST_END)
            begin
                status_q <= SRER_STATUS_RST;
                status_q[SRER_ST_SE_BIT]  <= rc_q && fail_w;
                status_q[SRER_ST_ERR_BIT] <= !rc_q && fail_w;
                error_q   <= rc_q ? SRER_BYTE_RST : ebyte_w;
                log_q     <= rc_q ? ebyte_w : SRER_BYTE_RST;
                res_lba_q <= first_lba_q;
                res_cnt_q <= cnt_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic end_lo_w;
    logic end_hi_w;
    assign end_lo_w = ce_i && (state_q == ST_END) && !hbs_q
                      && !(wr_en_w && sel_ctrl_w);
    assign end_hi_w = ce_i && (state_q == ST_END) && hbs_q
                      && !(wr_en_w && sel_ctrl_w);

    secnum_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        end_lo_w |=> secnum_w == $past(first_lba_q[7:0])
    ) else $error("sector number low byte wrong at end");
    secnum_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        end_hi_w |=> secnum_w == $past(first_lba_q[31:24])
    ) else $error("sector number high byte wrong at end");
    cyllo_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        end_lo_w |=> cyllo_w == $past(first_lba_q[15:8])
    ) else $error("cylinder low byte wrong at end");
    cyllo_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        end_hi_w |=> cyllo_w == $past(first_lba_q[39:32])
    ) else $error("cylinder low high byte wrong at end");
    cylhi_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        end_lo_w |=> cylhi_w == $past(first_lba_q[23:16])
    ) else $error("cylinder high byte wrong at end");
    cylhi_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        end_hi_w |=> cylhi_w == $past(first_lba_q[47:40])
    ) else $error("cylinder high high byte wrong at end");
    timeout_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && state_q == ST_RUN && expired_w && !rc_q)
        |=> ##1 error_q[SRER_ER_TIME_LIMIT_EXPIRED_FLAG_BIT] && end_q
    ) else $error("time limit flag not set after expiry");
    stream_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && state_q == ST_END && rc_q && fail_w)
        |=> status_q[SRER_ST_SE_BIT] && !status_q[SRER_ST_BSY_BIT]
    ) else $error("stream error flag missing");
    run_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && state_q == ST_END && have_err_q)
        |=> res_cnt_q == $past(cnt_q) && res_cnt_q != 16'h0000
    ) else $error("faulty sector count wrong");
    log_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && state_q == ST_END && rc_q)
        |=> error_q == 8'h00 && !status_q[SRER_ST_ERR_BIT]
            && log_q == $past(ebyte_w)
    ) else $error("continuous read errors not routed to log");

endmodule : srer_top
`default_nettype wire

// >>> srer_media_model.sv
// Purpose: media side stand-in that reports sector errors and transfer end
// Assumes: reports are one-cycle pulses launched right after a rising edge
// Notes:   released lines show the inverse of the last value, not a hold
`timescale 1ns/1ps
`default_nettype none
module srer_media_model
    import srer_pkg::*;
(
    input  wire logic     clk_i,
    output srer_media_type media_o,
    output logic           done_o
);
    initial
    begin
        media_o = '0;
        done_o  = 1'b0;
    end

    task automatic report(input logic [47:0] lba, input srer_err_type e);
        @(posedge clk_i);
        media_o <= '{1'b1, lba, e};
        @(posedge clk_i);
        // idle lines carry junk so a stale sample cannot pass
        media_o <= '{1'b0, ~lba, ~e};
    endtask : report

    task automatic finish();
        @(posedge clk_i);
        done_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
    endtask : finish
endmodule : srer_media_model
`default_nettype wire

// >>> tb_top.sv
// Purpose: self-checking bench for the stream read error report
// Assumes: short time limits: 300-cycle floor, 200 cycles per unit
// Notes:   registers reached only through the apb task
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import srer_pkg::*;
    localparam int unsigned MIN_CYC = 300;
    localparam srer_err_type E_UNC = 4'b0100;
    localparam srer_err_type E_MIX = 4'b1011;
    logic           clk_i = 1'b0;
    logic           rst_i = 1'b1;
    logic           ce = 1'b1;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [31:0]    paddr = '0;
    logic [31:0]    pwdata = '0;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    srer_media_type media;
    logic           done;
    logic           cmd_end;
    logic           busy;
    logic           cread;
    logic           stop;
    logic [31:0]    rd;
    logic           er;
    int             n;
    int             fail_count = 0;
    int             checks_done = 0;
    int             stops = 0;
    logic [47:0]    lba = 48'h8899_AABB_CCFE;

    always #2.5 clk_i = ~clk_i;

    // one early stop per command ended by an error or the time limit
    always @(posedge clk_i)
        if (stop === 1'b1)
            stops++;

    srer_top #(.COMPLETION_TIME_LIMIT_MIN_CYC(MIN_CYC), .COMPLETION_TIME_LIMIT_UNIT_US(1)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .media_i(media), .xfer_done_i(done),
        .busy_o(busy), .cont_read_o(cread), .stop_xfer_o(stop),
        .cmd_end_o(cmd_end));
    srer_media_model med_u (.clk_i(clk_i), .media_o(media), .done_o(done));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {24'h0, a};
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1 && k < 50)
        begin
            @(posedge clk_i);
            k++;
        end
        if (k == 50)
            chk(32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_end();
        n = 0;
        while (cmd_end !== 1'b1 && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 2000)
            chk(32'h0, 32'h1);
    endtask : wait_end

    task automatic chk_addr(input logic [47:0] a, input logic [31:0] cnt);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, SRER_OFS_CTRL, 32'h0);
            apb(1'b0, SRER_OFS_SECNUM + 8'(4 * i), 32'h0);
            chk(rd, {24'h0, a[8*i+:8]});
            apb(1'b1, SRER_OFS_CTRL, 32'h1);
            apb(1'b0, SRER_OFS_SECNUM + 8'(4 * i), 32'h0);
            chk(rd, {24'h0, a[8*i+24+:8]});
        end
        apb(1'b1, SRER_OFS_CTRL, 32'h0);
        apb(1'b0, SRER_OFS_SECCNT, 32'h0);
        chk(rd, cnt);
    endtask : chk_addr

    task automatic regs(input logic [31:0] st, input logic [31:0] e,
                        input logic [31:0] log);
        apb(1'b0, SRER_OFS_STATUS, 32'h0);
        chk(rd, st);
        apb(1'b0, SRER_OFS_ERROR, 32'h0);
        chk(rd, e);
        apb(1'b0, SRER_OFS_ERRLOG, 32'h0);
        chk(rd, log);
    endtask : regs

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(1'b0, SRER_OFS_STATUS, 32'h0);
        chk(rd, 32'h40);
        apb(1'b0, 8'h2C, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, SRER_OFS_STATUS, 32'hFF);
        chk({31'h0, er}, 32'h1);
        // plain streaming read: first error ends the command
        apb(1'b1, SRER_OFS_FEATURE, 32'h0);
        apb(1'b1, SRER_OFS_CMD, 32'h2B);
        med_u.report(lba, E_UNC);
        wait_end();
        regs(32'h41, 32'h40, 32'h00);
        chk_addr(lba, 32'h1);
        // continuous read: three consecutive bad sectors, carry into byte 1
        apb(1'b1, SRER_OFS_FEATURE, 32'h40);
        apb(1'b1, SRER_OFS_CMD, 32'h2B);
        for (int i = 0; i < 3; i++)
            med_u.report(lba + 48'(i), E_UNC);
        // a gap breaks the run; its error bits still reach the log
        med_u.report(lba + 48'h5, E_MIX);
        chk({30'h0, busy, cread}, 32'h3);
        med_u.finish();
        wait_end();
        regs(32'h60, 32'h00, 32'hD4);
        chk_addr(lba, 32'h3);
        // default limit of one unit is below the floor, so floor applies
        apb(1'b1, SRER_OFS_DEFCCTL, 32'h1);
        apb(1'b1, SRER_OFS_CMD, 32'h2B);
        wait_end();
        chk(32'(n >= MIN_CYC - 5 && n <= MIN_CYC + 5), 32'h1);
        regs(32'h60, 32'h00, 32'h01);
        // two units above the floor, no continuous read
        apb(1'b1, SRER_OFS_FEATURE, 32'h0200);
        apb(1'b1, SRER_OFS_CMD, 32'h2B);
        // frozen cycles must not count toward the limit
        ce <= 1'b0;
        repeat (20) @(posedge clk_i);
        ce <= 1'b1;
        wait_end();
        chk(32'(n >= 395 && n <= 405), 32'h1);
        regs(32'h41, 32'h01, 32'h00);
        chk(stops, 32'h3);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
